// ---- tcdma_pkg.sv ----
package tcdma_pkg;
	localparam int unsigned ADDR_W = 20;
	localparam int unsigned NSRC = 32;
	localparam int unsigned SEL_W = 5;
	localparam int unsigned NCH = 2;
	// Register word indices (byte address is four times the index)
	localparam logic [3:0] REG_CTRL0 = 4'h0;
	localparam logic [3:0] REG_SRC0 = 4'h1;
	localparam logic [3:0] REG_DST0 = 4'h2;
	localparam logic [3:0] REG_CNT0 = 4'h3;
	localparam logic [3:0] REG_CTRL1 = 4'h4;
	localparam logic [3:0] REG_SRC1 = 4'h5;
	localparam logic [3:0] REG_DST1 = 4'h6;
	localparam logic [3:0] REG_CNT1 = 4'h7;
	localparam logic [3:0] REG_STAT = 4'h8;
	localparam logic [3:0] REG_STRIDE = 4'h4;
	// Control field positions
	localparam int unsigned C_EN = 0;
	localparam int unsigned C_WORD = 1;
	localparam int unsigned C_RPT = 2;
	localparam int unsigned C_SINC = 3;
	localparam int unsigned C_DINC = 4;
	localparam int unsigned C_SWREQ = 5;
	localparam int unsigned C_BOTH = 6;
	localparam int unsigned C_SEL = 8;
	// Request source numbers
	localparam logic [SEL_W-1:0] SRC_SOFT = 5'h00;
	localparam logic [SEL_W-1:0] SRC_PIN_A = 5'h01;
	localparam logic [SEL_W-1:0] SRC_PIN_B = 5'h02;
	// Protected register window
	localparam logic [ADDR_W-1:0] PROT_LO = 20'h00020;
	localparam logic [ADDR_W-1:0] PROT_HI = 20'h0003f;
	localparam logic [ADDR_W-1:0] STEP_BYTE = 20'h00001;
	localparam logic [ADDR_W-1:0] STEP_WORD = 20'h00002;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] CNT_ONE = 16'h0001;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [15:0] wdata;
		logic rd;
		logic wr;
		logic word;
	} tcdma_bus_t;

	typedef struct packed {
		logic [SEL_W-1:0] sel;
		logic both;
		logic dinc;
		logic sinc;
		logic rpt;
		logic word;
		logic en;
	} tcdma_cfg_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_READ = 2'b01,
		ST_WRITE = 2'b10
	} tcdma_state_t;
endpackage

// ---- tcdma_sync.sv ----
`timescale 1ns/1ps
module tcdma_sync
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Asynchronous pins and their synchronised level
	input wire logic [1:0] pin_in,
	output logic [1:0] pin_out
);
	import tcdma_pkg::*;
	typedef struct packed {
		logic [1:0] s1;
		logic [1:0] s2;
	} tcdma_sync_st_t;
	tcdma_sync_st_t st_q, st_d;
	always_comb
	begin
		st_d.s1 = pin_in;
		st_d.s2 = st_q.s1;
	end
	always_ff @(posedge clk)
	begin
		if (rst)
			st_q <= '1; // Pins idle high, so no edge is seen after reset
		else
			st_q <= st_d;
	end
	assign pin_out = st_q.s2;
endmodule // tcdma_sync

// ---- tcdma_trig.sv ----
`timescale 1ns/1ps
module tcdma_trig
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Synchronised pins and peripheral request pulses
	input wire logic [1:0] pin_lvl,
	input wire logic [tcdma_pkg::NSRC-1:0] periph_req,
	// Selection
	input wire logic [tcdma_pkg::SEL_W-1:0] sel,
	input wire logic both,
	// Trigger: one cycle per falling pin edge (and per pin A rising edge when both is set), follows the selected peripheral request level
	output logic trig
);
	import tcdma_pkg::*;
	typedef struct packed {
		logic [1:0] last;
	} tcdma_trig_st_t;
	tcdma_trig_st_t st_q, st_d;
	logic fall_a, rise_a, fall_b;
	always_comb
	begin
		st_d.last = pin_lvl;
	end
	always_ff @(posedge clk)
	begin
		if (rst)
			st_q <= '1; // Matches the synchroniser's idle level
		else
			st_q <= st_d;
	end
	assign fall_a = st_q.last[0] & ~pin_lvl[0];
	assign rise_a = ~st_q.last[0] & pin_lvl[0];
	assign fall_b = st_q.last[1] & ~pin_lvl[1];
	// Only observes request lines; never touches the interrupt system
	always_comb
	begin
		if (sel == SRC_PIN_A)
			trig = fall_a | (both & rise_a);
		else if (sel == SRC_PIN_B)
			trig = fall_b;
		else if (sel == SRC_SOFT)
			trig = 1'b0;
		else
			trig = periph_req[sel];
	end
endmodule // tcdma_trig

// ---- tcdma_top.sv ----
`timescale 1ns/1ps
module tcdma_top
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Request sources
	input wire logic ext_irq_pin_a,
	input wire logic ext_irq_pin_b,
	input wire logic [tcdma_pkg::NSRC-1:0] periph_req,
	// System bus master
	output logic bus_req,
	output tcdma_pkg::tcdma_bus_t bus_out,
	input wire logic [15:0] bus_rdata,
	// Completion requests
	output logic [1:0] done_irq
);
	import tcdma_pkg::*;

	typedef struct packed {
		tcdma_cfg_t [NCH-1:0] cfg;
		logic [NCH-1:0][ADDR_W-1:0] src;
		logic [NCH-1:0][ADDR_W-1:0] dst;
		logic [NCH-1:0][15:0] reload;
		logic [NCH-1:0][ADDR_W-1:0] fwd;
		logic [NCH-1:0][15:0] cnt;
		logic [NCH-1:0] fresh;
		logic [NCH-1:0] pend;
		logic [NCH-1:0] prot_err;
		logic [NCH-1:0] done;
		logic [NCH-1:0] swreq;
		tcdma_state_t state;
		logic ch;
		logic [15:0] data;
		logic [31:0] rdata;
		tcdma_bus_t bus;
		logic breq;
	} tcdma_st_t;

	tcdma_st_t st_q, st_d;
	logic [1:0] pin_lvl;
	logic [NCH-1:0] trig;

	tcdma_sync u_sync
	(
		.clk(clk),
		.rst(rst),
		.pin_in({ext_irq_pin_b, ext_irq_pin_a}),
		.pin_out(pin_lvl)
	);

	genvar g;
	generate
		for (g = 0; g < NCH; g++)
		begin : g_trig
			tcdma_trig u_trig
			(
				.clk(clk),
				.rst(rst),
				.pin_lvl(pin_lvl),
				.periph_req(periph_req),
				.sel(st_q.cfg[g].sel),
				.both(st_q.cfg[g].both),
				.trig(trig[g])
			);
		end
	endgenerate

	function automatic logic in_prot(input logic [ADDR_W-1:0] a);
		in_prot = (a >= PROT_LO) && (a <= PROT_HI);
	endfunction

	always_comb
	begin
		logic c;
		logic [ADDR_W-1:0] sa, da, step, nf;
		logic [15:0] nc;
		logic [3:0] base;
		c = 1'b0;
		sa = '0;
		da = '0;
		step = '0;
		nf = '0;
		nc = '0;
		base = '0;
		st_d = st_q;
		st_d.done = '0;
		st_d.swreq = '0;
		st_d.rdata = '0;
		// Register writes
		for (int i = 0; i < NCH; i++)
		begin
			base = 4'(i) * REG_STRIDE;
			if (reg_wr && reg_addr == base + REG_CTRL0)
			begin
				st_d.cfg[i].en = reg_wdata[C_EN];
				st_d.cfg[i].word = reg_wdata[C_WORD];
				st_d.cfg[i].rpt = reg_wdata[C_RPT];
				st_d.cfg[i].sinc = reg_wdata[C_SINC];
				st_d.cfg[i].dinc = reg_wdata[C_DINC];
				st_d.cfg[i].both = reg_wdata[C_BOTH];
				st_d.cfg[i].sel = reg_wdata[C_SEL +: SEL_W];
				st_d.swreq[i] = reg_wdata[C_SWREQ];
				if (reg_wdata[C_EN] && !st_q.cfg[i].en)
					st_d.fresh[i] = 1'b1;
				if (reg_wdata[C_EN])
					st_d.prot_err[i] = 1'b0;
			end
			// Fixed pointers writable only while disabled
			if (reg_wr && reg_addr == base + REG_SRC0 &&
				(st_q.cfg[i].sinc || !st_q.cfg[i].en))
				st_d.src[i] = reg_wdata[ADDR_W-1:0];
			if (reg_wr && reg_addr == base + REG_DST0 &&
				(st_q.cfg[i].dinc || !st_q.cfg[i].en))
				st_d.dst[i] = reg_wdata[ADDR_W-1:0];
			if (reg_wr && reg_addr == base + REG_CNT0)
				st_d.reload[i] = reg_wdata[15:0];
			// Reads
			if (reg_rd && reg_addr == base + REG_CTRL0)
				st_d.rdata = 32'({st_q.cfg[i].sel, 1'b0,
					st_q.cfg[i].both, 1'b0, st_q.cfg[i].dinc,
					st_q.cfg[i].sinc, st_q.cfg[i].rpt,
					st_q.cfg[i].word, st_q.cfg[i].en});
			if (reg_rd && reg_addr == base + REG_SRC0)
				st_d.rdata = 32'((st_q.cfg[i].en && st_q.cfg[i].sinc
					&& !st_q.fresh[i]) ? st_q.fwd[i] : st_q.src[i]);
			if (reg_rd && reg_addr == base + REG_DST0)
				st_d.rdata = 32'((st_q.cfg[i].en && st_q.cfg[i].dinc
					&& !st_q.fresh[i]) ? st_q.fwd[i] : st_q.dst[i]);
			if (reg_rd && reg_addr == base + REG_CNT0)
				st_d.rdata = 32'(st_q.cnt[i]);
			// Single pending flag; extra triggers merge
			if (st_d.cfg[i].en && (trig[i] || st_d.swreq[i]))
				st_d.pend[i] = 1'b1;
			if (!st_d.cfg[i].en)
				st_d.pend[i] = 1'b0;
		end
		if (reg_rd && reg_addr == REG_STAT)
			st_d.rdata = 32'({st_q.prot_err, st_q.pend,
				st_q.cfg[1].en, st_q.cfg[0].en});

		c = st_q.ch;
		step = st_q.cfg[c].word ? STEP_WORD : STEP_BYTE;
		sa = st_q.cfg[c].sinc ? st_q.fwd[c] : st_q.src[c];
		da = st_q.cfg[c].dinc ? st_q.fwd[c] : st_q.dst[c];
		case (st_q.state)
			ST_IDLE:
			begin
				st_d.bus = '0;
				st_d.breq = 1'b0;
				if (st_q.pend != '0)
				begin
					c = !st_q.pend[0];
					st_d.ch = c;
					// A trigger in this same cycle stays pending
					st_d.pend[c] = st_d.cfg[c].en &&
						(trig[c] || st_d.swreq[c]);
					if (st_q.fresh[c])
					begin
						st_d.fresh[c] = 1'b0;
						st_d.fwd[c] = st_q.cfg[c].sinc ?
							st_q.src[c] : st_q.dst[c];
						st_d.cnt[c] = st_q.reload[c];
					end
					sa = st_q.cfg[c].sinc ? st_d.fwd[c] : st_q.src[c];
					da = st_q.cfg[c].dinc ? st_d.fwd[c] : st_q.dst[c];
					// Both ends checked before the bus is taken
					if (in_prot(sa) || in_prot(da))
					begin
						st_d.prot_err[c] = 1'b1;
						st_d.cfg[c].en = 1'b0;
						st_d.pend[c] = 1'b0;
					end
					else
					begin
						st_d.breq = 1'b1;
						st_d.bus.rd = 1'b1;
						st_d.bus.addr = sa;
						st_d.bus.word = st_q.cfg[c].word;
						st_d.state = ST_READ;
					end
				end
			end
			ST_READ:
			begin
				st_d.data = bus_rdata;
				st_d.bus.rd = 1'b0;
				if (in_prot(da))
				begin
					st_d.prot_err[c] = 1'b1;
					st_d.cfg[c].en = 1'b0;
					st_d.pend[c] = 1'b0;
					st_d.breq = 1'b0;
					st_d.state = ST_IDLE;
				end
				else
				begin
					st_d.bus.wr = 1'b1;
					st_d.bus.addr = da;
					st_d.bus.wdata = bus_rdata;
					st_d.state = ST_WRITE;
				end
			end
			ST_WRITE:
			begin
				st_d.bus = '0;
				st_d.breq = 1'b0;
				st_d.state = ST_IDLE;
				nf = st_q.fwd[c] + step;
				st_d.fwd[c] = nf;
				nc = st_q.cnt[c] - CNT_ONE;
				st_d.cnt[c] = nc;
				if (st_q.cnt[c] == CNT_ZERO)
				begin
					st_d.done[c] = 1'b1;
					if (st_q.cfg[c].rpt)
					begin
						st_d.cnt[c] = st_q.reload[c];
						st_d.fresh[c] = 1'b1;
					end
					else
					begin
						st_d.cfg[c].en = 1'b0;
						st_d.pend[c] = 1'b0;
					end
				end
			end
			default:
			begin
				st_d.state = ST_IDLE;
				st_d.bus = '0;
				st_d.breq = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign reg_rdata = st_q.rdata;
	assign bus_req = st_q.breq;
	assign bus_out = st_q.bus;
	assign done_irq = st_q.done;

	////////////////////////////////////////////////////////////////////////
	// Assertions

	a_write_after_read: assert property (@(posedge clk)
		disable iff (rst)
		st_q.bus.rd |=> st_q.bus.wr || !st_q.breq)
		else $error("read not followed by write");
	a_bus_release: assert property (@(posedge clk)
		disable iff (rst)
		st_q.bus.wr |=> !st_q.breq)
		else $error("bus not returned after write");
	a_bus_idle: assert property (@(posedge clk)
		disable iff (rst)
		!st_q.breq |-> !st_q.bus.rd && !st_q.bus.wr)
		else $error("bus strobe without ownership");
	a_prio_zero: assert property (@(posedge clk)
		disable iff (rst)
		(st_q.state == ST_IDLE && st_q.pend[0]) |=> st_q.ch == 1'b0)
		else $error("channel 0 not served first");
	a_no_prot: assert property (@(posedge clk)
		disable iff (rst)
		(st_q.bus.rd || st_q.bus.wr) |-> !in_prot(st_q.bus.addr))
		else $error("protected address accessed");
	a_prot_stop: assert property (@(posedge clk)
		disable iff (rst)
		$rose(st_q.prot_err[0]) |-> !st_q.cfg[0].en)
		else $error("protected channel still enabled");
	a_single_off: assert property (@(posedge clk)
		disable iff (rst)
		(st_q.done[0] && !$past(st_q.cfg[0].rpt))
		|-> !st_q.cfg[0].en)
		else $error("single mode channel still enabled");
	a_single_one: assert property (@(posedge clk)
		disable iff (rst)
		(st_q.done[1] && !$past(st_q.cfg[1].rpt))
		|-> !st_q.cfg[1].en)
		else $error("single mode channel still enabled");
	a_repeat_on: assert property (@(posedge clk)
		disable iff (rst)
		(st_q.done[0] && $past(st_q.cfg[0].rpt) && !$past(reg_wr))
		|-> st_q.cfg[0].en && st_q.cnt[0] == st_q.reload[0])
		else $error("repeat mode did not reload");
	a_cnt_step: assert property (@(posedge clk)
		disable iff (rst)
		(st_q.state == ST_WRITE && !st_q.ch &&
		st_q.cnt[0] != CNT_ZERO) |=>
		st_q.cnt[0] == $past(st_q.cnt[0]) - CNT_ONE)
		else $error("transfer counter did not step");
	a_done_pulse: assert property (@(posedge clk)
		disable iff (rst)
		st_q.done[0] |=> !st_q.done[0])
		else $error("completion not a pulse");
	a_done_one: assert property (@(posedge clk)
		disable iff (rst)
		st_q.done[1] |=> !st_q.done[1])
		else $error("completion not a pulse");
	a_start_bus: assert property (@(posedge clk)
		disable iff (rst)
		(st_q.state == ST_IDLE && st_q.pend != '0) |=>
		(st_q.breq || st_q.prot_err != '0))
		else $error("pending request not started");
	a_dis_nopend: assert property (@(posedge clk)
		disable iff (rst)
		!st_q.cfg[1].en |-> !st_q.pend[1])
		else $error("pending while disabled");
	a_dis_zero: assert property (@(posedge clk)
		disable iff (rst)
		!st_q.cfg[0].en |-> !st_q.pend[0])
		else $error("pending while disabled");
endmodule // tcdma_top

// ---- tcdma_mem_model.sv ----
`timescale 1ns/1ps
module tcdma_mem_model
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Bus driven by the controller
	input wire logic bus_req,
	input wire tcdma_pkg::tcdma_bus_t bus_out,
	// Read answer
	output logic [15:0] bus_rdata
);
	import tcdma_pkg::*;
	logic [15:0] last_q;
	////////////////////////////////////////////////////////////////////////
	// Answers in the same cycle; pattern depends on the address
	always_comb
	begin
		if (bus_req && bus_out.rd)
			bus_rdata = {bus_out.addr[7:0] ^ 8'h5a, bus_out.addr[7:0]};
		else
			bus_rdata = ~last_q;
	end
	// Released bus flips every cycle so stale data never looks valid
	always_ff @(posedge clk)
	begin
		if (rst)
			last_q <= 16'h0000;
		else
			last_q <= bus_rdata;
	end
endmodule // tcdma_mem_model

// ---- tb_two_channel_cycle_steal_dma.sv ----
`timescale 1ns/1ps
module tb_two_channel_cycle_steal_dma;
	import tcdma_pkg::*;
	logic clk;
	logic rst;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [31:0] reg_rdata;
	logic ext_irq_pin_a;
	logic ext_irq_pin_b;
	logic [NSRC-1:0] periph_req;
	logic bus_req;
	tcdma_bus_t bus_out;
	logic [15:0] bus_rdata;
	logic [1:0] done_irq;
	int fails;
	int samples_checked;
	////////////////////////////////////////////////////////////////////////
	tcdma_top uut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .ext_irq_pin_a(ext_irq_pin_a),
		.ext_irq_pin_b(ext_irq_pin_b), .periph_req(periph_req),
		.bus_req(bus_req), .bus_out(bus_out), .bus_rdata(bus_rdata),
		.done_irq(done_irq));
	tcdma_mem_model mem (.clk(clk), .rst(rst), .bus_req(bus_req),
		.bus_out(bus_out), .bus_rdata(bus_rdata));
	always #12.5 clk = ~clk;
	////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	task automatic cfg(input int ch, input logic [19:0] s,
		input logic [19:0] d, input logic [31:0] ctl);
		logic [3:0] b;
		b = 4'(ch * 4);
		wr_reg(b + REG_SRC0, {12'h000, s});
		wr_reg(b + REG_DST0, {12'h000, d});
		wr_reg(b + REG_CNT0, 32'h0);
		wr_reg(b + REG_CTRL0, ctl);
	endtask
	task automatic quiet(input int n);
		repeat (n)
		begin
			@(posedge clk);
			#1;
			chk(bus_req, 32'h0);
		end
	endtask
	// One transfer: read source, write destination, then completion
	task automatic xfer(input logic [19:0] s, input logic [19:0] d,
		input logic w, input logic [1:0] dn);
		int n;
		logic [15:0] e;
		n = 0;
		e = {s[7:0] ^ 8'h5a, s[7:0]};
		#1;
		while (bus_out.rd !== 1'b1 && n < 12)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(bus_req, 32'h1);
		chk(bus_out.addr, s);
		chk(bus_out.word, w);
		@(posedge clk);
		#1;
		chk(bus_out.wr, 32'h1);
		chk(bus_out.addr, d);
		if (w)
			chk(bus_out.wdata, e);
		else
			chk(bus_out.wdata[7:0], e[7:0]);
		@(posedge clk);
		#1;
		chk(done_irq, dn);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		logic [31:0] v;
		rd_reg(REG_STAT, v);
		chk(v, 32'h0);
		rd_reg(4'hf, v);
		chk(v, 32'h0);
		chk(bus_req, 32'h0);
		$display("test reset done");
	endtask
	task automatic t_soft();
		logic [31:0] v;
		cfg(0, 20'h01000, 20'h02000, 32'h0b);
		wr_reg(REG_CNT0, 32'h1);
		wr_reg(REG_CTRL0, 32'h2b);
		xfer(20'h01000, 20'h02000, 1'b1, 2'b00);
		rd_reg(REG_CNT0, v);
		chk(v, 32'h0);
		wr_reg(REG_CTRL0, 32'h2b);
		xfer(20'h01002, 20'h02000, 1'b1, 2'b01);
		rd_reg(REG_STAT, v);
		chk(v, 32'h0);
		$display("test soft done");
	endtask
	task automatic t_pins();
		logic [31:0] v;
		cfg(0, 20'h00100, 20'h00200, 32'h0101);
		cfg(1, 20'h00300, 20'h00400, 32'h0201);
		@(posedge clk);
		ext_irq_pin_a <= 1'b0;
		ext_irq_pin_b <= 1'b0;
		xfer(20'h00100, 20'h00200, 1'b0, 2'b01);
		xfer(20'h00300, 20'h00400, 1'b0, 2'b10);
		@(posedge clk);
		ext_irq_pin_b <= 1'b1;
		wr_reg(REG_CTRL0, 32'h0141);
		ext_irq_pin_a <= 1'b1;
		xfer(20'h00100, 20'h00200, 1'b0, 2'b01);
		rd_reg(REG_STAT, v);
		chk(v, 32'h0);
		$display("test pins done");
	endtask
	// Channel 1 stays pending behind channel 0, so the second cycle of its two-cycle request merges
	task automatic t_merge();
		logic [31:0] v;
		cfg(0, 20'h00500, 20'h00600, 32'h0a05);
		cfg(1, 20'h00700, 20'h00800, 32'h0c11);
		@(posedge clk);
		periph_req[10] <= 1'b1;
		periph_req[12] <= 1'b1;
		@(posedge clk);
		periph_req[10] <= 1'b0;
		@(posedge clk);
		periph_req[12] <= 1'b0;
		xfer(20'h00500, 20'h00600, 1'b0, 2'b01);
		xfer(20'h00700, 20'h00800, 1'b0, 2'b10);
		quiet(10);
		rd_reg(REG_STAT, v);
		chk(v, 32'h1);
		@(posedge clk);
		periph_req[10] <= 1'b1;
		@(posedge clk);
		periph_req[10] <= 1'b0;
		xfer(20'h00500, 20'h00600, 1'b0, 2'b01);
		wr_reg(REG_CTRL0, 32'h0);
		$display("test merge done");
	endtask
	task automatic t_protect(input int ch, input logic [19:0] s,
		input logic [19:0] d, input logic [31:0] ctl,
		input logic [31:0] st);
		logic [31:0] v;
		cfg(ch, s, d, ctl);
		wr_reg(4'(ch * 4) + REG_CTRL0, ctl | 32'h20);
		quiet(10);
		rd_reg(REG_STAT, v);
		chk(v, st);
		$display("test protect %0d done", ch);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		#(25 * 3000);
		fails++;
		summarize();
	end
	initial
	begin
		clk = 1'b0;
		rst = 1'b1;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		ext_irq_pin_a = 1'b1;
		ext_irq_pin_b = 1'b1;
		periph_req = '0;
		fails = 0;
		samples_checked = 0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_soft();
		t_pins();
		t_merge();
		t_protect(0, 20'h00020, 20'h02000, 32'h0b, 32'h10);
		t_protect(1, 20'h01000, 20'h0003f, 32'h01, 32'h30);
		summarize();
	end
endmodule // tb_two_channel_cycle_steal_dma
